/* File: common/adcsif_defines.svh */
`ifndef ADCSIF_DEFINES_SVH
`define ADCSIF_DEFINES_SVH
// Register byte offsets on the configuration link.
`define ADCSIF_OFF_DIE_ID 11'h000
`define ADCSIF_OFF_RST_PWR 11'h004
`define ADCSIF_OFF_SDI_CTL 11'h008
`define ADCSIF_OFF_SDO_CTL 11'h00C
`define ADCSIF_OFF_DOUT_CTL 11'h010
`define ADCSIF_OFF_PATTERN 11'h014
`define ADCSIF_OFF_CLK_BLOCK 11'h1D0
// Reset values.
`define ADCSIF_RST_REG 32'h00000000
`define ADCSIF_RST_DIE_ID 32'h000000A5
// Field positions.
`define ADCSIF_SDI_CPHA 0
`define ADCSIF_SDI_CPOL 1
`define ADCSIF_SDO_PROTO 0
`define ADCSIF_SDO_SRC_SYNC 1
`define ADCSIF_SDO_LANES_LO 2
`define ADCSIF_SDO_LANES_HI 3
`define ADCSIF_SDO_DDR 4
`define ADCSIF_SDO_SSCLK_LO 6
`define ADCSIF_SDO_SSCLK_HI 7
`define ADCSIF_RST_SOFT 0
`define ADCSIF_DOUT_PATTERN 0
`define ADCSIF_CLK_BLOCK_BIT 0
// Configuration frame: write flag, 11-bit address, 32-bit data.
`define ADCSIF_FRAME_BITS 6'h2C
`endif

/* File: common/adcsif_pkg.sv */
package adcsif_pkg;
   typedef enum logic [1:0] {
      ADCSIF_IDLE = 2'b00,
      ADCSIF_FRAME = 2'b01,
      ADCSIF_DONE = 2'b11
   } adcsif_state_e;
   typedef enum logic [1:0] {
      ADCSIF_LANE1 = 2'b00,
      ADCSIF_LANE2 = 2'b01,
      ADCSIF_LANE4 = 2'b11
   } adcsif_lanes_e;
endpackage : adcsif_pkg

/* File: common/adcsif_clk_if.sv */
`timescale 1ns/1ps
interface adcsif_clk_if;
   logic [1:0] sel;
   logic sclk_lvl;
   logic clk_lvl;
   logic clk_rise;
   logic clk_fall;
   modport core (output sel, output sclk_lvl, input clk_lvl, input clk_rise, input clk_fall);
   modport gen (input sel, input sclk_lvl, output clk_lvl, output clk_rise, output clk_fall);
endinterface : adcsif_clk_if

/* File: logic/adcsif_clk_gen.sv */
`timescale 1ns/1ps
module adcsif_clk_gen (
   input wire logic mclk,
   input wire logic rst,
   adcsif_clk_if.gen cif
);
   logic [2:0] div_q, div_d;
   logic lvl_q, lvl_d;
   logic rise_q, rise_d;
   logic fall_q, fall_d;

   // Code 00 follows the host clock; 01/10/11 use the internal clock /2, /4, /8.
   always_comb begin // see RULE_07
      div_d = div_q + 3'h1;
      case (cif.sel)
         2'b00: lvl_d = cif.sclk_lvl;
         2'b01: lvl_d = div_q[0];
         2'b10: lvl_d = div_q[1];
         2'b11: lvl_d = div_q[2];
         default: lvl_d = 1'b0;
      endcase
      rise_d = lvl_d & ~lvl_q;
      fall_d = ~lvl_d & lvl_q;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_q <= 3'h0;
         lvl_q <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else begin
         div_q <= div_d;
         lvl_q <= lvl_d;
         rise_q <= rise_d;
         fall_q <= fall_d;
      end
   end

   assign cif.clk_lvl = lvl_q;
   assign cif.clk_rise = rise_q;
   assign cif.clk_fall = fall_q;

   chk_div_src: assert property (@(posedge mclk) disable iff (rst)
      (cif.sel == 2'b01) ##1 (cif.sel == 2'b01)
      |=> (cif.clk_lvl != $past(cif.clk_lvl))) // see RULE_07
      else $error("internal clock divider stalled");
endmodule : adcsif_clk_gen

/* File: logic/adcsif_core.sv */
// What this block does
// RULE_01: Configuration always uses standard link on input lane.
// RULE_02: Output uses one, two or four lanes.
// RULE_03: Selectable standard or enhanced output protocol.
// RULE_04: Standard mode supports all four polarity/phase combinations.
// RULE_05: Enhanced mode: source- or system-synchronous clock.
// RULE_06: Enhanced mode: single or double data rate.
// RULE_07: Clock select: host clock, internal /1, /2, /4; the code divides mclk by 2, 4, 8.
// RULE_08: Block bit set ignores nonzero clock select writes.
// RULE_09: Reset restores all registers and protocol settings.
`timescale 1ns/1ps
`include "adcsif_defines.svh"
module adcsif_core #(
   parameter int DATA_W = 16,
   parameter logic [31:0] DIE_ID = `ADCSIF_RST_DIE_ID // Arbitrary value.
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic [DATA_W-1:0] conv_data,
   output logic [3:0] sdo,
   output logic rclk
);
   if (DATA_W < 4 || DATA_W > 32 || DATA_W % 4 != 0) begin : g_chk
      $error("DATA_W must be a multiple of 4 between 4 and 32");
   end

   adcsif_clk_if cif ();
   adcsif_clk_gen u_gen (.mclk(mclk), .rst(rst), .cif(cif));

   logic [31:0] sdi_ctl_q, sdi_ctl_d, sdo_ctl_q, sdo_ctl_d;
   logic [31:0] dout_ctl_q, dout_ctl_d, pat_q, pat_d, blk_q, blk_d, rpw_q, rpw_d;
   logic [43:0] in_sr_q, in_sr_d;
   logic [5:0] cnt_q, cnt_d;
   logic [31:0] out_sr_q, out_sr_d, rd_data_q, rd_data_d;
   logic rd_pend_q, rd_pend_d, rd_act_q, rd_act_d;
   logic [3:0] sdo_q, sdo_d;
   logic sclk_q;
   logic rclk_q, rclk_d;
   adcsif_pkg::adcsif_state_e st_q, st_d;
   logic s_rise, s_fall, lead, trail, cap_edge, host_launch, launch, frame_end;
   logic enh, ddr, src, cpol, cpha;
   logic [1:0] lanes;
   logic [10:0] addr;
   logic [31:0] wdata, rdmux;
   logic [DATA_W-1:0] sample;

   assign cpha = sdi_ctl_q[`ADCSIF_SDI_CPHA];
   assign cpol = sdi_ctl_q[`ADCSIF_SDI_CPOL];
   assign enh = sdo_ctl_q[`ADCSIF_SDO_PROTO]; // see RULE_03
   assign src = sdo_ctl_q[`ADCSIF_SDO_SRC_SYNC];
   assign ddr = sdo_ctl_q[`ADCSIF_SDO_DDR];
   assign lanes = sdo_ctl_q[`ADCSIF_SDO_LANES_HI:`ADCSIF_SDO_LANES_LO];
   assign s_rise = sclk & ~sclk_q;
   assign s_fall = ~sclk & sclk_q;
   // Leading edge is the first edge away from the idle level set by polarity.
   assign lead = cpol ? s_fall : s_rise; // see RULE_04
   assign trail = cpol ? s_rise : s_fall; // see RULE_04
   // Configuration capture ignores the output protocol select entirely.
   assign cap_edge = ~cs_n & (cpha ? trail : lead); // see RULE_01
   assign host_launch = cpha ? lead : trail;
   assign addr = in_sr_q[42:32];
   assign wdata = in_sr_q[31:0];
   assign frame_end = (st_q == adcsif_pkg::ADCSIF_FRAME) & cs_n;
   assign cif.sel = sdo_ctl_q[`ADCSIF_SDO_SSCLK_HI:`ADCSIF_SDO_SSCLK_LO];
   assign cif.sclk_lvl = sclk;
   assign sample = dout_ctl_q[`ADCSIF_DOUT_PATTERN] ? pat_q[DATA_W-1:0] : conv_data;

   // Output launch edge selection per protocol.
   always_comb begin
      if (!enh) begin
         launch = host_launch; // see RULE_04
      end else if (src) begin
         launch = cif.clk_rise | (ddr & cif.clk_fall); // see RULE_05, RULE_06
      end else begin
         launch = s_rise | (ddr & s_fall); // see RULE_05, RULE_06
      end
   end

   always_comb begin
      case (addr)
         `ADCSIF_OFF_DIE_ID: rdmux = DIE_ID;
         `ADCSIF_OFF_RST_PWR: rdmux = rpw_q;
         `ADCSIF_OFF_SDI_CTL: rdmux = sdi_ctl_q;
         `ADCSIF_OFF_SDO_CTL: rdmux = sdo_ctl_q;
         `ADCSIF_OFF_DOUT_CTL: rdmux = dout_ctl_q;
         `ADCSIF_OFF_PATTERN: rdmux = pat_q;
         `ADCSIF_OFF_CLK_BLOCK: rdmux = blk_q;
         default: rdmux = 32'h00000000;
      endcase
   end

   // Frame sequencer and configuration register file.
   always_comb begin
      st_d = st_q;
      in_sr_d = in_sr_q;
      cnt_d = cnt_q;
      sdi_ctl_d = sdi_ctl_q;
      sdo_ctl_d = sdo_ctl_q;
      dout_ctl_d = dout_ctl_q;
      pat_d = pat_q;
      blk_d = blk_q;
      rpw_d = rpw_q;
      rd_pend_d = rd_pend_q;
      rd_data_d = rd_data_q;
      case (st_q)
         adcsif_pkg::ADCSIF_IDLE: begin
            if (!cs_n) begin
               st_d = adcsif_pkg::ADCSIF_FRAME;
               cnt_d = 6'h00;
               rd_pend_d = 1'b0;
            end
         end
         adcsif_pkg::ADCSIF_FRAME: begin
            if (cs_n) begin
               st_d = adcsif_pkg::ADCSIF_DONE;
            end else if (cap_edge) begin
               in_sr_d = {in_sr_q[42:0], sdi}; // see RULE_01
               if (cnt_q != 6'h3F) begin
                  cnt_d = cnt_q + 6'h01;
               end
            end
         end
         adcsif_pkg::ADCSIF_DONE: begin
            st_d = adcsif_pkg::ADCSIF_IDLE;
            if (cnt_q == `ADCSIF_FRAME_BITS && in_sr_q[43]) begin
               case (addr)
                  `ADCSIF_OFF_RST_PWR: rpw_d = wdata;
                  `ADCSIF_OFF_SDI_CTL: sdi_ctl_d = wdata;
                  `ADCSIF_OFF_SDO_CTL: begin
                     sdo_ctl_d = wdata;
                     // A blocked nonzero clock select keeps the old field.
                     if (blk_q[`ADCSIF_CLK_BLOCK_BIT] &&
                         wdata[`ADCSIF_SDO_SSCLK_HI:`ADCSIF_SDO_SSCLK_LO] != 2'b00) begin
                        sdo_ctl_d[`ADCSIF_SDO_SSCLK_HI:`ADCSIF_SDO_SSCLK_LO] =
                           sdo_ctl_q[`ADCSIF_SDO_SSCLK_HI:`ADCSIF_SDO_SSCLK_LO]; // see RULE_08
                     end
                  end
                  `ADCSIF_OFF_DOUT_CTL: dout_ctl_d = wdata;
                  `ADCSIF_OFF_PATTERN: pat_d = wdata;
                  `ADCSIF_OFF_CLK_BLOCK: blk_d = wdata;
                  default: ;
               endcase
               // Soft reset restores every register, itself included.
               if (addr == `ADCSIF_OFF_RST_PWR && wdata[`ADCSIF_RST_SOFT]) begin
                  rpw_d = `ADCSIF_RST_REG; // see RULE_09
                  sdi_ctl_d = `ADCSIF_RST_REG;
                  sdo_ctl_d = `ADCSIF_RST_REG;
                  dout_ctl_d = `ADCSIF_RST_REG;
                  pat_d = `ADCSIF_RST_REG;
                  blk_d = `ADCSIF_RST_REG;
               end
            end else if (cnt_q == `ADCSIF_FRAME_BITS) begin
               rd_pend_d = 1'b1;
               rd_data_d = rdmux;
            end
         end
         default: st_d = adcsif_pkg::ADCSIF_IDLE;
      endcase
   end

   // Output shifter: register reads go out on lane 0 in the next frame.
   always_comb begin
      out_sr_d = out_sr_q;
      rd_act_d = rd_act_q;
      sdo_d = sdo_q;
      rclk_d = (enh & src) ? cif.clk_lvl : 1'b0; // see RULE_05
      if (st_q == adcsif_pkg::ADCSIF_IDLE && !cs_n) begin
         rd_act_d = rd_pend_q;
         out_sr_d = rd_pend_q ? rd_data_q : {sample, {(32 - DATA_W){1'b0}}};
      end else if (!cs_n && launch) begin
         if (rd_act_q || lanes == adcsif_pkg::ADCSIF_LANE1) begin
            out_sr_d = {out_sr_q[30:0], 1'b0};
         end else if (lanes == adcsif_pkg::ADCSIF_LANE2) begin
            out_sr_d = {out_sr_q[29:0], 2'b00}; // see RULE_02
         end else if (lanes == adcsif_pkg::ADCSIF_LANE4) begin
            out_sr_d = {out_sr_q[27:0], 4'h0}; // see RULE_02
         end else begin
            out_sr_d = {out_sr_q[30:0], 1'b0};
         end
      end
      if (rd_act_d || lanes == adcsif_pkg::ADCSIF_LANE1 || lanes == 2'b10) begin
         sdo_d = {3'b000, out_sr_d[31]};
      end else if (lanes == adcsif_pkg::ADCSIF_LANE2) begin
         sdo_d = {2'b00, out_sr_d[31:30]};
      end else begin
         sdo_d = out_sr_d[31:28];
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin // see RULE_09
         st_q <= adcsif_pkg::ADCSIF_IDLE;
         in_sr_q <= 44'h00000000000;
         cnt_q <= 6'h00;
         sdi_ctl_q <= `ADCSIF_RST_REG;
         sdo_ctl_q <= `ADCSIF_RST_REG;
         dout_ctl_q <= `ADCSIF_RST_REG;
         pat_q <= `ADCSIF_RST_REG;
         blk_q <= `ADCSIF_RST_REG;
         rpw_q <= `ADCSIF_RST_REG;
         rd_pend_q <= 1'b0;
         rd_data_q <= 32'h00000000;
         rd_act_q <= 1'b0;
         out_sr_q <= 32'h00000000;
         sdo_q <= 4'h0;
         rclk_q <= 1'b0;
         sclk_q <= 1'b0;
      end else begin
         st_q <= st_d;
         in_sr_q <= in_sr_d;
         cnt_q <= cnt_d;
         sdi_ctl_q <= sdi_ctl_d;
         sdo_ctl_q <= sdo_ctl_d;
         dout_ctl_q <= dout_ctl_d;
         pat_q <= pat_d;
         blk_q <= blk_d;
         rpw_q <= rpw_d;
         rd_pend_q <= rd_pend_d;
         rd_data_q <= rd_data_d;
         rd_act_q <= rd_act_d;
         out_sr_q <= out_sr_d;
         sdo_q <= sdo_d;
         rclk_q <= rclk_d;
         sclk_q <= sclk;
      end
   end

   assign sdo = sdo_q;
   assign rclk = rclk_q;

   chk_cfg_ignores_mode: assert property (@(posedge mclk) disable iff (rst)
      (st_q == adcsif_pkg::ADCSIF_FRAME && !cs_n && cap_edge) |=>
      in_sr_q[0] == $past(sdi)) // see RULE_01
      else $error("configuration bit not captured from input lane");
   chk_lane_one_idle: assert property (@(posedge mclk) disable iff (rst)
      (lanes == adcsif_pkg::ADCSIF_LANE1) |=> sdo_q[3:1] == 3'b000) // see RULE_02
      else $error("unused output lanes driven in single lane mode");
   chk_std_no_rclk: assert property (@(posedge mclk) disable iff (rst)
      !enh |=> !rclk_q) // see RULE_03
      else $error("output clock running in standard protocol");
   chk_cpol_edge: assert property (@(posedge mclk) disable iff (rst)
      (!enh && !cs_n && !cpha && cpol && s_rise && lanes == adcsif_pkg::ADCSIF_LANE1
       && st_q == adcsif_pkg::ADCSIF_FRAME) |=>
      out_sr_q == {$past(out_sr_q[30:0]), 1'b0}) // see RULE_04
      else $error("standard mode missed its launch edge");
   chk_src_clock: assert property (@(posedge mclk) disable iff (rst)
      (enh && src) ##1 (enh && src) |-> rclk_q == $past(cif.clk_lvl)) // see RULE_05
      else $error("source synchronous clock not forwarded");
   chk_sdr_fall: assert property (@(posedge mclk) disable iff (rst)
      (enh && !src && !ddr && s_fall && !s_rise && st_q == adcsif_pkg::ADCSIF_FRAME && !cs_n)
      |=> out_sr_q == $past(out_sr_q)) // see RULE_06
      else $error("single data rate shifted on falling edge");
   chk_ssclk_block: assert property (@(posedge mclk) disable iff (rst)
      (blk_q[`ADCSIF_CLK_BLOCK_BIT] && st_q == adcsif_pkg::ADCSIF_DONE && in_sr_q[43]
       && addr == `ADCSIF_OFF_SDO_CTL && wdata[7:6] != 2'b00 && cnt_q == `ADCSIF_FRAME_BITS)
      |=> sdo_ctl_q[7:6] == $past(sdo_ctl_q[7:6])) // see RULE_08
      else $error("blocked clock select write took effect");
   chk_reset_state: assert property (@(posedge mclk)
      $fell(rst) |-> sdo_ctl_q == `ADCSIF_RST_REG && sdi_ctl_q == `ADCSIF_RST_REG
      && st_q == adcsif_pkg::ADCSIF_IDLE) // see RULE_09
      else $error("registers not at reset value after reset");
   cov_quad: cover property (@(posedge mclk) disable iff (rst)
      lanes == adcsif_pkg::ADCSIF_LANE4 && launch && !cs_n);
   cov_ddr_src: cover property (@(posedge mclk) disable iff (rst)
      enh && src && ddr && cif.clk_fall && !cs_n);
   cov_write: cover property (@(posedge mclk) disable iff (rst)
      st_q == adcsif_pkg::ADCSIF_DONE && in_sr_q[43] && cnt_q == `ADCSIF_FRAME_BITS);
endmodule : adcsif_core

/* File: bench/adcsif_host.sv */
`timescale 1ns/1ps
module adcsif_host (
   input wire logic mclk,
   input wire logic [3:0] sdo,
   input wire logic rclk,
   output logic sclk,
   output logic cs_n,
   output logic sdi
);
   logic cpol = 1'h0;
   logic cpha = 1'h0;
   logic rclk_q;
   logic [3:0] cap [0:43];
   int rclk_cnt = 0;
   initial begin
      sclk = 1'h0;
      cs_n = 1'h1;
      sdi = 1'h0;
   end
   // Only edges inside a frame count, so each frame reports its own forwarded clock.
   always @(posedge mclk) begin
      rclk_q <= rclk;
      if (!cs_n && rclk && !rclk_q) rclk_cnt <= rclk_cnt + 1;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : hold
   task automatic set_mode(input logic [1:0] m);
      cpha = m[0];
      cpol = m[1];
      sclk = m[1];
      hold(4);
   endtask : set_mode
   // Four cycles per half period keep the edges well apart and the data held past each edge.
   task automatic frame(input logic [43:0] w);
      rclk_cnt = 0;
      cs_n = 1'h0;
      hold(4);
      for (int i = 0; i < 44; i++) begin
         if (cpha) sclk = ~cpol;
         sdi = w[43-i];
         hold(4);
         cap[i] = sdo;
         sclk = ~sclk;
         hold(4);
         if (!cpha) sclk = cpol;
      end
      cs_n = 1'h1;
      // The lane is inverted between frames, so it must not keep the last bit.
      sdi = ~sdi;
      hold(4);
   endtask : frame
endmodule : adcsif_host

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   localparam logic [31:0] DIE_ID_T = 32'h0000005A; // Arbitrary value.
   logic mclk = 1'h0;
   logic rst = 1'h1;
   logic [15:0] conv_data = 16'h0000;
   logic [3:0] sdo;
   logic rclk;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic [31:0] rd_v;
   int err_total = 0;
   int total_checks = 0;
   always #2.5 mclk = ~mclk;
   adcsif_core #(.DIE_ID(DIE_ID_T)) dut_u (
      .mclk(mclk),
      .rst(rst),
      .sclk(sclk),
      .cs_n(cs_n),
      .sdi(sdi),
      .conv_data(conv_data),
      .sdo(sdo),
      .rclk(rclk)
   );
   adcsif_host host_u (
      .mclk(mclk),
      .sdo(sdo),
      .rclk(rclk),
      .sclk(sclk),
      .cs_n(cs_n),
      .sdi(sdi)
   );
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [10:0] a, input logic [31:0] d);
      host_u.frame({1'h1, a, d});
   endtask : wr
   // A read answers in the following frame, so the address is simply sent twice.
   task automatic rchk(input string nm, input logic [10:0] a, input logic [31:0] e);
      host_u.frame({1'h0, a, 32'h00000000});
      host_u.frame({1'h0, a, 32'h00000000});
      for (int i = 0; i < 32; i++) rd_v[31-i] = host_u.cap[i][0];
      check(nm, rd_v, e);
   endtask : rchk
   task automatic lanes(input string nm, input int n, input int step, input logic [15:0] d);
      logic [3:0] e;
      int b;
      host_u.frame({1'h0, 11'h018, 32'h00000000});
      for (int k = 0; k < 20; k++) begin
         e = 4'h0;
         for (int j = 0; j < n; j++) begin
            b = 15 - step * k - (n - 1 - j);
            if (b >= 0) e[j] = d[b];
         end
         check(nm, {28'h0000000, host_u.cap[k]}, {28'h0000000, e});
      end
   endtask : lanes
   task automatic t_reset;
      rchk("die id", 11'h000, DIE_ID_T);
      for (int a = 4; a <= 20; a += 4) rchk("reg reset", a[10:0], 32'h00000000);
      rchk("block reset", 11'h1D0, 32'h00000000);
      rchk("unmapped", 11'h018, 32'h00000000);
      wr(11'h000, 32'hFFFFFFFF);
      rchk("die id ro", 11'h000, DIE_ID_T);
      $display("test reset done");
   endtask : t_reset
   task automatic t_modes;
      logic [15:0] p;
      for (int m = 0; m < 4; m++) begin
         p = 16'h5A3C ^ {14'h0000, m[1:0]};
         wr(11'h008, {30'h00000000, m[1:0]});
         host_u.set_mode(m[1:0]);
         wr(11'h014, {16'h0000, p});
         wr(11'h008, 32'h00000000);
         host_u.set_mode(2'h0);
         rchk("mode write", 11'h014, {16'h0000, p});
      end
      $display("test modes done");
   endtask : t_modes
   task automatic t_lanes;
      int n;
      wr(11'h014, 32'h0000B38D);
      wr(11'h010, 32'h00000001);
      for (int c = 0; c < 4; c++) begin
         n = (c == 3) ? 4 : (c == 1) ? 2 : 1;
         wr(11'h00C, {28'h0000000, c[1:0], 2'h0});
         lanes("lanes", n, n, 16'hB38D);
         check("rclk std", host_u.rclk_cnt, 32'h00000000);
      end
      wr(11'h010, 32'h00000000);
      wr(11'h00C, 32'h00000000);
      conv_data = 16'h6C35;
      lanes("conv", 1, 1, 16'h6C35);
      $display("test lanes done");
   endtask : t_lanes
   task automatic t_enh;
      int cnt [0:3];
      wr(11'h00C, 32'h00000011);
      lanes("ddr", 1, 2, 16'h6C35);
      check("rclk sys", host_u.rclk_cnt, 32'h00000000);
      wr(11'h00C, 32'h00000013);
      lanes("src ddr", 1, 2, 16'h6C35);
      check("rclk src", host_u.rclk_cnt, 32'h0000002C);
      wr(11'h00C, 32'h00000001);
      lanes("sdr", 1, 1, 16'h6C35);
      wr(11'h014, 32'h00001234);
      rchk("enh cfg", 11'h014, 32'h00001234);
      for (int c = 0; c < 4; c++) begin
         wr(11'h00C, {24'h000000, c[1:0], 6'h03});
         host_u.frame({1'h0, 11'h018, 32'h00000000});
         cnt[c] = host_u.rclk_cnt;
      end
      check("rclk sclk", cnt[0], 32'h0000002C);
      check("rclk div", {31'h0, cnt[1] > cnt[2] && cnt[2] > cnt[3] && cnt[3] > 0}, 1);
      wr(11'h00C, 32'h00000000);
      $display("test enhanced done");
   endtask : t_enh
   task automatic t_block;
      wr(11'h1D0, 32'h00000001);
      wr(11'h00C, 32'h000000CC);
      rchk("blocked 11", 11'h00C, 32'h0000000C);
      wr(11'h00C, 32'h00000044);
      rchk("blocked 01", 11'h00C, 32'h00000004);
      wr(11'h1D0, 32'h00000000);
      wr(11'h00C, 32'h00000080);
      rchk("unblocked", 11'h00C, 32'h00000080);
      wr(11'h1D0, 32'h00000001);
      wr(11'h00C, 32'h00000000);
      rchk("code 00", 11'h00C, 32'h00000000);
      $display("test block done");
   endtask : t_block
   task automatic t_soft;
      wr(11'h014, 32'h00007777);
      wr(11'h00C, 32'h0000000C);
      wr(11'h004, 32'h00000001);
      rchk("soft pat", 11'h014, 32'h00000000);
      rchk("soft out", 11'h00C, 32'h00000000);
      rchk("soft ctl", 11'h004, 32'h00000000);
      wr(11'h014, 32'h00001111);
      wr(11'h1D0, 32'h00000001);
      rst = 1'h1;
      host_u.hold(3);
      rst = 1'h0;
      host_u.hold(2);
      rchk("hard pat", 11'h014, 32'h00000000);
      rchk("hard blk", 11'h1D0, 32'h00000000);
      $display("test reset again done");
   endtask : t_soft
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   initial begin
      host_u.hold(3);
      rst = 1'h0;
      host_u.hold(2);
      t_reset;
      t_modes;
      t_lanes;
      t_enh;
      t_block;
      t_soft;
      close_out;
   end
   // The tests need about 40k cycles; twice that means a hang.
   initial begin
      #400000;
      err_total++;
      close_out;
   end
endmodule : tb_top
